// ==== hdl/sef_pkg.sv ====
// Purpose: shared constants and types for the serial EEPROM front end
// Assumes: 25 MHz system clock, 8-bit words, 15-bit word address
// Notes:   time figures are kept in their own unit, cycle counts derived
package sef_pkg;
   // Word and address geometry
   localparam int         BYTE_W        = 8;
   localparam int         ADDR_W        = 15;
   localparam logic [2:0] BIT_FIRST     = 3'h0;
   localparam logic [2:0] BIT_LAST      = 3'h7;

   // Self-timed write cycle, longest time rounded down to cycles
   localparam int         WRITE_TIME_US = 5000;
   localparam int         CLK_MHZ       = 25;
   localparam int         WRITE_CYC     = WRITE_TIME_US * CLK_MHZ;
   localparam int         CNT_W         = 17;

   // Block protection levels
   localparam logic [1:0] BP_NONE       = 2'h0;
   localparam logic [1:0] BP_QUARTER    = 2'h1;
   localparam logic [1:0] BP_HALF       = 2'h2;
   localparam logic [1:0] BP_ALL        = 2'h3;
   localparam logic [1:0] TOP_QUARTER   = 2'h3;

   // Kind of nonvolatile write asked for by the command core
   typedef enum logic [1:0] {WR_NONE, WR_ARRAY, WR_STATUS} sef_wr_kind_t;

   typedef struct packed {
      sef_wr_kind_t         kind;
      logic [ADDR_W-1:0]    addr;
   } sef_wr_req_t;

   typedef struct packed {
      logic [1:0]           level;
      logic                 dense;
   } sef_prot_cfg_t;

   typedef enum logic {WS_IDLE, WS_CYCLE} sef_wr_state_t;
endpackage : sef_pkg

// ==== hdl/sef_front_end.sv ====
// Purpose: SPI serial front end of a byte-wide EEPROM with pause and protect pin
// Assumes: SPI clock is a clock port; chip select high ends the frame
// Notes:   system side sees bytes through a two-entry buffer
`timescale 1ns/1ns
`default_nettype none
module sef_front_end
#(
   parameter int WRITE_CYCLES = sef_pkg::WRITE_CYC
)
(
   input  wire logic                  i_clk,           // System clock
   input  wire logic                  i_sys_rst,       // Sync reset, high
   input  wire logic                  i_sck,           // Serial clock
   input  wire logic                  i_cs_n,          // Chip select
   input  wire logic                  i_si,            // Serial data in
   input  wire logic                  i_hold_n,        // Pause, low
   input  wire logic                  i_wp_n,          // Write protect pin
   input  wire logic                  i_protect_enable_bit, // Pin enable
   input  wire sef_pkg::sef_prot_cfg_t i_prot_cfg,     // Block protection
   input  wire sef_pkg::sef_wr_req_t  i_wr_req,        // Pending write
   input  wire logic                  i_rx_ready,      // Core takes byte
   input  wire logic [7:0]            i_tx_byte,       // Read data
   input  wire logic                  i_tx_valid,      // Read data valid
   input  wire logic                  i_overrun_clr,   // Clear overrun
   output logic                       o_so,            // Serial data out
   output logic                       o_so_oe_n,       // Out enable, low
   output logic [7:0]                 o_rx_byte,       // Received byte
   output logic                       o_rx_valid,      // Byte waiting
   output logic                       o_rx_room,       // Buffer not full
   output logic                       o_rx_overrun,    // Byte lost, sticky
   output logic                       o_tx_ready,      // Read data taken
   output logic                       o_selected,      // Frame active
   output logic                       o_busy,          // Write cycle runs
   output logic                       o_wr_commit,     // Write started
   output logic                       o_wr_reject,     // Write refused
   output logic                       o_addr_prot      // Address locked
);
   localparam int CW = sef_pkg::CNT_W;

   // Address falls inside the locked top part of the array
   function automatic logic addr_locked(input logic [14:0] a,
                                        input sef_pkg::sef_prot_cfg_t c);
      logic [1:0] top;
      top = c.dense ? a[14:13] : a[13:12];
      case (c.level)
         sef_pkg::BP_QUARTER: addr_locked = (top == sef_pkg::TOP_QUARTER);
         sef_pkg::BP_HALF:    addr_locked = top[1];
         sef_pkg::BP_ALL:     addr_locked = 1'b1;
         default:             addr_locked = 1'b0;
      endcase
   endfunction : addr_locked

   // Serial clock domain
   logic [2:0] bit_cnt_r;
   logic [6:0] sh_in_r;
   logic [7:0] rx_word_r;
   logic       rx_tog_r;
   logic [7:0] sh_out_r;
   logic       drive_r;
   logic       so_r;
   logic       taken_tog_r;
   logic       txq_s1_r;
   logic       txq_s2_r;
   logic       oe_n_r;
   logic       so_off;
   logic       drive_nxt;

   // System clock domain
   logic       cs_s1_r, cs_s2_r, cs_q_r;
   logic       wp_s1_r, wp_s2_r;
   logic       rx_s1_r, rx_s2_r, rx_seen_r;
   logic       ack_s1_r, ack_s2_r;
   logic [7:0] tx_word_r;
   logic       tx_tog_r;
   logic [7:0] head_r, spare_r;
   logic       head_v_r, spare_v_r, overrun_r;
   logic       push, pop;
   logic       abort_r;
   logic       cs_rise, wp_block;
   sef_pkg::sef_wr_state_t wstate_r;
   logic [CW-1:0] wcnt_r;
   logic       commit_r, reject_r, prot_r;

   // Frame logic resets while deselected, so each frame starts clean
   always_ff @(posedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         bit_cnt_r <= sef_pkg::BIT_FIRST;
         sh_in_r   <= '0;
      end
      else if (i_hold_n)
      begin
         sh_in_r   <= {sh_in_r[5:0], i_si};
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   // Completed byte and its toggle clear with the frame when chip select goes high
   always_ff @(posedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         rx_tog_r  <= 1'b0;
         rx_word_r <= '0;
      end
      else if (i_hold_n && bit_cnt_r == sef_pkg::BIT_LAST)
      begin
         rx_word_r <= {sh_in_r, i_si};
         rx_tog_r  <= ~rx_tog_r;
      end
   end

   // Read data request, level synchroniser on the falling edge
   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         txq_s1_r <= 1'b0;
         txq_s2_r <= 1'b0;
      end
      else
      begin
         txq_s1_r <= tx_tog_r;
         txq_s2_r <= txq_s1_r;
      end
   end

   // Output shifter; modes 0 and 3 both change data on the falling edge
   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         sh_out_r    <= '0;
         drive_r     <= 1'b0;
         so_r        <= 1'b0;
         taken_tog_r <= 1'b0;
      end
      else if (i_hold_n)
      begin
         if (bit_cnt_r == sef_pkg::BIT_FIRST)
         begin
            if (txq_s2_r != taken_tog_r)
            begin
               sh_out_r    <= tx_word_r;
               so_r        <= tx_word_r[7];
               drive_r     <= 1'b1;
               taken_tog_r <= ~taken_tog_r;
            end
            else
            begin
               drive_r <= 1'b0;
            end
         end
         else
         begin
            sh_out_r <= {sh_out_r[6:0], 1'b0};
            so_r     <= sh_out_r[6];
         end
      end
   end

   // Release is immediate; drive resumes at the next falling edge
   assign so_off = i_cs_n | ~i_hold_n;

   // Enable follows the word loaded at this fall, so bit 7 is driven at once
   assign drive_nxt = (bit_cnt_r == sef_pkg::BIT_FIRST) ? (txq_s2_r != taken_tog_r) : drive_r;

   always_ff @(negedge i_sck or posedge so_off)
   begin
      if (so_off)
         oe_n_r <= 1'b1;
      else
         oe_n_r <= ~drive_nxt;
   end

   assign o_so      = so_r;
   assign o_so_oe_n = oe_n_r;

   // Pin synchronisers into the system clock
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_q_r  <= 1'b1;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
      end
      else
      begin
         cs_s1_r <= i_cs_n;
         cs_s2_r <= cs_s1_r;
         cs_q_r  <= cs_s2_r;
         wp_s1_r <= i_wp_n;
         wp_s2_r <= wp_s1_r;
      end
   end

   // Toggle synchronisers from the serial clock
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         rx_s1_r   <= 1'b0;
         rx_s2_r   <= 1'b0;
         rx_seen_r <= 1'b0;
         ack_s1_r  <= 1'b0;
         ack_s2_r  <= 1'b0;
      end
      else
      begin
         rx_s1_r   <= rx_tog_r;
         rx_s2_r   <= rx_s1_r;
         rx_seen_r <= rx_s2_r;
         ack_s1_r  <= taken_tog_r;
         ack_s2_r  <= ack_s1_r;
      end
   end

   // While deselected the serial toggles fall back to zero silently
   assign push    = ~cs_s2_r & (rx_s2_r != rx_seen_r);
   assign pop     = head_v_r & i_rx_ready;
   assign cs_rise = cs_s2_r & ~cs_q_r;

   // Read data word, held until the serial side takes it
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || cs_s2_r)
      begin
         tx_tog_r   <= 1'b0;
         tx_word_r  <= '0;
         o_tx_ready <= 1'b0;
      end
      else if (i_tx_valid && o_tx_ready)
      begin
         tx_word_r  <= i_tx_byte;
         tx_tog_r   <= ~tx_tog_r;
         o_tx_ready <= 1'b0;
      end
      else
      begin
         o_tx_ready <= (tx_tog_r == ack_s2_r);
      end
   end

   // Two-entry receive buffer; the master cannot be stalled, so loss is flagged
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         head_r    <= '0;
         spare_r   <= '0;
         head_v_r  <= 1'b0;
         spare_v_r <= 1'b0;
      end
      else if (pop)
      begin
         if (spare_v_r)
         begin
            head_r    <= spare_r;
            spare_r   <= rx_word_r;
            spare_v_r <= push;
         end
         else
         begin
            head_r   <= rx_word_r;
            head_v_r <= push;
         end
      end
      else if (push && !head_v_r)
      begin
         head_r   <= rx_word_r;
         head_v_r <= 1'b1;
      end
      else if (push && !spare_v_r)
      begin
         spare_r   <= rx_word_r;
         spare_v_r <= 1'b1;
      end
   end

   // Overrun is sticky; a new loss wins over the clear
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         overrun_r <= 1'b0;
      else if (push && head_v_r && spare_v_r && !pop)
         overrun_r <= 1'b1;
      else if (i_overrun_clr)
         overrun_r <= 1'b0;
   end

   assign o_rx_byte    = head_r;
   assign o_rx_valid   = head_v_r;
   assign o_rx_room    = ~spare_v_r;
   assign o_rx_overrun = overrun_r;

   // Protect pin only counts when the enable bit is set
   assign wp_block = i_protect_enable_bit & ~wp_s2_r;

   // Abort latch for a status write; the set wins over the frame-start clear
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         abort_r <= 1'b0;
      else if (!cs_s2_r && i_wr_req.kind == sef_pkg::WR_STATUS && wp_block)
         abort_r <= 1'b1;
      else if (!cs_s2_r && cs_q_r)
         abort_r <= 1'b0;
   end

   // Self-timed write cycle, started only when chip select rises
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         wstate_r <= sef_pkg::WS_IDLE;
         wcnt_r   <= '0;
         commit_r <= 1'b0;
         reject_r <= 1'b0;
      end
      else
      begin
         commit_r <= 1'b0;
         reject_r <= 1'b0;
         case (wstate_r)
            sef_pkg::WS_IDLE:
            begin
               if (cs_rise && i_wr_req.kind == sef_pkg::WR_STATUS)
               begin
                  if (abort_r || wp_block)
                     reject_r <= 1'b1;
                  else
                  begin
                     commit_r <= 1'b1;
                     wcnt_r   <= CW'(WRITE_CYCLES - 1);
                     wstate_r <= sef_pkg::WS_CYCLE;
                  end
               end
               else if (cs_rise && i_wr_req.kind == sef_pkg::WR_ARRAY)
               begin
                  if (addr_locked(i_wr_req.addr, i_prot_cfg))
                     reject_r <= 1'b1;
                  else
                  begin
                     commit_r <= 1'b1;
                     wcnt_r   <= CW'(WRITE_CYCLES - 1);
                     wstate_r <= sef_pkg::WS_CYCLE;
                  end
               end
            end
            sef_pkg::WS_CYCLE:
            begin
               // Pin is not looked at here, the cycle always runs out
               if (wcnt_r == '0)
                  wstate_r <= sef_pkg::WS_IDLE;
               else
                  wcnt_r <= wcnt_r - 1'b1;
               reject_r <= cs_rise && i_wr_req.kind != sef_pkg::WR_NONE;
            end
            default:
               wstate_r <= sef_pkg::WS_IDLE;
         endcase
      end
   end

   // Status flags for the command core
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         prot_r <= 1'b0;
      else
         prot_r <= addr_locked(i_wr_req.addr, i_prot_cfg);
   end

   assign o_selected  = ~cs_s2_r;
   assign o_busy      = (wstate_r == sef_pkg::WS_CYCLE);
   assign o_wr_commit = commit_r;
   assign o_wr_reject = reject_r;
   assign o_addr_prot = prot_r;
endmodule : sef_front_end
`default_nettype wire

// ==== test/sef_front_end_properties.sv ====
// Purpose: port checks for the serial EEPROM front end
// Assumes: bound to the front end with its cycle count
// Notes:   write results judged a few clocks after select rises
`timescale 1ns/1ns
`default_nettype none
module sef_front_end_checker
#(
   parameter int WRITE_CYCLES = 20
)
(
   input wire logic                 i_clk,                // Clock
   input wire logic                 i_sys_rst,            // Reset
   input wire logic                 i_cs_n,               // Select
   input wire logic                 i_hold_n,             // Pause
   input wire logic                 i_wp_n,               // Protect pin
   input wire logic                 i_protect_enable_bit, // Pin enable
   input wire sef_pkg::sef_wr_req_t i_wr_req,             // Write request
   input wire logic                 o_so_oe_n,            // Out enable
   input wire logic                 o_selected,           // Selected
   input wire logic                 o_busy,               // Write cycle
   input wire logic                 o_wr_commit,          // Started
   input wire logic                 o_wr_reject           // Refused
);
   int busy_len_r;
   // Length of the current busy stretch
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !o_busy)
         busy_len_r <= 0;
      else
         busy_len_r <= busy_len_r + 1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_desel_hiz; i_cs_n |-> o_so_oe_n; endproperty
   a_desel_hiz: assert property (p_desel_hiz) else $error("output driven while deselected");
   property p_pause_hiz; !i_hold_n |-> o_so_oe_n; endproperty
   a_pause_hiz: assert property (p_pause_hiz) else $error("output driven while paused");
   property p_select; !i_cs_n [*4] |-> o_selected; endproperty
   a_select: assert property (p_select) else $error("select not seen");
   property p_end; i_cs_n [*4] |-> !o_selected; endproperty
   a_end: assert property (p_end) else $error("frame not ended");
   property p_pulse; o_wr_commit |=> !o_wr_commit && !o_wr_reject; endproperty
   a_pulse: assert property (p_pulse) else $error("second write result");
   property p_start; o_wr_commit |-> o_busy && !$past(o_busy); endproperty
   a_start: assert property (p_start) else $error("commit without new cycle");
   property p_len; $fell(o_busy) |-> busy_len_r == WRITE_CYCLES; endproperty
   a_len: assert property (p_len) else $error("write cycle length wrong");
   property p_locked;
      $rose(i_cs_n) && i_wr_req.kind == sef_pkg::WR_STATUS && i_protect_enable_bit && !i_wp_n
         |-> ##[2:5] o_wr_reject;
   endproperty
   a_locked: assert property (p_locked) else $error("status write not refused");
   property p_free;
      $rose(i_cs_n) && i_wr_req.kind == sef_pkg::WR_STATUS && !i_protect_enable_bit && !o_busy
         |-> ##[2:5] o_wr_commit;
   endproperty
   a_free: assert property (p_free) else $error("status write not started");
endmodule : sef_front_end_checker
bind sef_front_end sef_front_end_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_clk, .i_sys_rst, .i_cs_n,
   .i_hold_n, .i_wp_n, .i_protect_enable_bit, .i_wr_req, .o_so_oe_n, .o_selected, .o_busy, .o_wr_commit,
   .o_wr_reject);
`default_nettype wire

// ==== test/sef_spi_master.sv ====
// Purpose: SPI bus master model for the front end pins
// Assumes: modes 0 and 3, 15 ns serial clock period
// Notes:   serial clock stands still between frames
`timescale 1ns/1ns
`default_nettype none
module sef_spi_master
(
   output logic     o_sck,     // Serial clock
   output logic     o_cs_n,    // Chip select
   output logic     o_si,      // Data to device
   output logic     o_hold_n,  // Pause
   input wire logic i_so,      // Data from device
   input wire logic i_so_oe_n  // Device drives, low
);
   logic cpol = 1'b0;
   logic last = 1'b0;
   // Released line shows inverse of last bit, not a stale copy
   always @(i_so or i_so_oe_n) if (!i_so_oe_n) last = i_so;
   wire logic line = i_so_oe_n ? ~last : i_so;
   // Deselected from power-up
   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   task automatic open_frame(input logic m3);
      cpol = m3;
      o_sck = m3;
      #20 o_cs_n = 1'b0;
      #20;
   endtask : open_frame
   // One byte, MSB first; optional pause with clock toggling inside
   task automatic xfer(input logic [7:0] tx, input logic pz, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         o_sck = 1'b0;
         o_si = tx[i];
         #7;
         if (pz && i == 4)
         begin
            o_hold_n = 1'b0;
            repeat (4)
            begin
               #7 o_sck = 1'b1;
               o_si = ~tx[i];
               #8 o_sck = 1'b0;
            end
            o_si = tx[i];
            #3 o_hold_n = 1'b1;
            #4;
         end
         o_sck = 1'b1;
         rx[i] = line;
         #8;
      end
      #7 o_sck = cpol;
      #120;
   endtask : xfer
   task automatic close_frame();
      #80 o_cs_n = 1'b1;
   endtask : close_frame
endmodule : sef_spi_master
`default_nettype wire

// ==== test/test_sef_front_end.sv ====
// Purpose: self-checking bench for the serial EEPROM front end
// Assumes: short write cycle, master model on the serial pins
// Notes:   random bytes and addresses from a fixed seed
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module test_sef_front_end;
   logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, pen = 1'b0, rx_rdy = 1'b1, tx_v = 1'b0, ov_clr = 1'b0;
   logic [7:0] tx_b = 8'h00, rx_b;
   sef_pkg::sef_prot_cfg_t cfg = '0;
   sef_pkg::sef_wr_req_t req = '0;
   logic sck, cs_n, si, hold_n, so, so_oe_n, rx_v, room, ovr, tx_rdy, sel, busy, com, rej, aprot;
   logic [7:0] got[$], want[$];
   logic [31:0] rv;
   int seed = 32'h1522, errors = 0, checked = 0, tests = 0;
   always #20 clk = ~clk;
   sef_front_end #(.WRITE_CYCLES(40)) u_sef_front_end (.i_clk(clk), .i_sys_rst(rst), .i_sck(sck),
      .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .i_protect_enable_bit(pen),
      .i_prot_cfg(cfg), .i_wr_req(req), .i_rx_ready(rx_rdy), .i_tx_byte(tx_b), .i_tx_valid(tx_v),
      .i_overrun_clr(ov_clr), .o_so(so), .o_so_oe_n(so_oe_n), .o_rx_byte(rx_b), .o_rx_valid(rx_v),
      .o_rx_room(room), .o_rx_overrun(ovr), .o_tx_ready(tx_rdy), .o_selected(sel), .o_busy(busy),
      .o_wr_commit(com), .o_wr_reject(rej), .o_addr_prot(aprot));
   sef_spi_master u_sef_spi_master (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
      .i_so(so), .i_so_oe_n(so_oe_n));
   // Collect every byte the core takes
   always @(posedge clk) if (rx_v === 1'b1 && rx_rdy === 1'b1) got.push_back(rx_b);
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic wait_on(ref logic s, input logic v);
      int k;
      for (k = 0; k < 200 && s !== v; k++) @(negedge clk);
      if (k == 200)
      begin
         errors++;
         wrap_up();
      end
   endtask : wait_on
   function automatic logic locked(input sef_pkg::sef_prot_cfg_t c, input logic [sef_pkg::ADDR_W-1:0] a);
      logic [1:0] r;
      r = c.dense ? a[14:13] : a[13:12];
      return c.level == sef_pkg::BP_ALL || (c.level == sef_pkg::BP_HALF && r[1])
         || (c.level == sef_pkg::BP_QUARTER && r == sef_pkg::TOP_QUARTER);
   endfunction : locked
   // Busy refuses all; status also refused when the pin was low under enable, array when its address is locked
   function automatic logic exp_rej(input sef_pkg::sef_wr_kind_t k, input logic en, input logic wp,
                                    input logic drop, input logic bzy, input logic lk);
      if (k == sef_pkg::WR_STATUS)
         return bzy || (en && (!wp || drop));
      return bzy || lk;
   endfunction : exp_rej
   task automatic cmp_rx(input int n);
      repeat (6) @(negedge clk);
      `CHK(got.size(), n)
      for (int i = 0; i < n && i < got.size(); i++)
         `CHK(got[i], want[i])
      got.delete();
      want.delete();
   endtask : cmp_rx
   // One frame: optional read word, optional pin drop, then write result
   task automatic frame(input logic m3, input sef_pkg::sef_wr_kind_t k, input logic en, input logic wp,
                        input logic drop, input logic bzy, input int nb, input logic rd);
      logic [7:0] tw, d, r;
      logic c, j, er;
      if (!bzy)
         wait_on(busy, 1'b0);
      @(negedge clk);
      pen = en;
      wp_n = wp;
      rv = $random(seed);
      req = '{k, rv[14:0]};
      tw = rv[30:23];
      repeat (3) @(negedge clk);
      u_sef_spi_master.open_frame(m3);
      if (rd)
      begin
         wait_on(tx_rdy, 1'b1);
         tx_b = tw;
         tx_v = 1'b1;
         @(negedge clk);
         tx_v = 1'b0;
      end
      for (int i = 0; i < nb; i++)
      begin
         rv = $random(seed);
         d = rv[7:0];
         want.push_back(d);
         u_sef_spi_master.xfer(d, i == 0 && nb > 1, r);
         if (rd && i == 1)
            `CHK(r, tw)
      end
      if (drop)
      begin
         @(negedge clk);
         wp_n = 1'b0;
         repeat (4) @(negedge clk);
         wp_n = 1'b1;
         repeat (3) @(negedge clk);
      end
      u_sef_spi_master.close_frame();
      c = 1'b0;
      j = 1'b0;
      repeat (8)
      begin
         @(negedge clk);
         c |= com;
         j |= rej;
      end
      er = exp_rej(k, en, wp, drop, bzy, locked(cfg, req.addr));
      req.kind = sef_pkg::WR_NONE;
      `CHK(j, k != sef_pkg::WR_NONE && er)
      `CHK(c, k != sef_pkg::WR_NONE && !er)
      if (rx_rdy)
         cmp_rx(nb);
      tests++;
      $display("test %0d done", tests);
   endtask : frame
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      `CHK({sel, busy, ovr}, 3'h0)
      for (int l = 0; l < 8; l++)
         repeat (3)
         begin
            rv = $random(seed);
            cfg = '{l[2:1], l[0]};
            req.addr = rv[14:0];
            repeat (2) @(negedge clk);
            `CHK(aprot, locked(cfg, req.addr))
         end
      tests++;
      $display("test %0d done", tests);
      cfg = '0;
      frame(1'b0, sef_pkg::WR_STATUS, 1'b1, 1'b1, 1'b0, 1'b0, 2, 1'b0);
      frame(1'b1, sef_pkg::WR_STATUS, 1'b1, 1'b0, 1'b0, 1'b0, 1, 1'b0);
      frame(1'b0, sef_pkg::WR_STATUS, 1'b0, 1'b0, 1'b0, 1'b0, 1, 1'b0);
      frame(1'b1, sef_pkg::WR_ARRAY, 1'b1, 1'b1, 1'b1, 1'b1, 1, 1'b0);
      frame(1'b0, sef_pkg::WR_STATUS, 1'b1, 1'b1, 1'b1, 1'b0, 2, 1'b0);
      cfg = '{sef_pkg::BP_ALL, 1'b1};
      frame(1'b1, sef_pkg::WR_ARRAY, 1'b0, 1'b1, 1'b0, 1'b0, 1, 1'b0);
      cfg = '0;
      frame(1'b0, sef_pkg::WR_ARRAY, 1'b0, 1'b1, 1'b0, 1'b0, 1, 1'b0);
      frame(1'b0, sef_pkg::WR_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 2, 1'b1);
      frame(1'b1, sef_pkg::WR_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 2, 1'b1);
      // Stalled core: third byte overflows the two slots
      rx_rdy = 1'b0;
      frame(1'b0, sef_pkg::WR_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 3, 1'b0);
      `CHK({room, ovr}, 2'h1)
      rx_rdy = 1'b1;
      cmp_rx(2);
      ov_clr = 1'b1;
      @(negedge clk);
      ov_clr = 1'b0;
      @(negedge clk);
      `CHK({room, ovr}, 2'h2)
      tests++;
      $display("test %0d done", tests);
      wrap_up();
   end
endmodule : test_sef_front_end
`default_nettype wire
